// ### verilog/ebac_core.sv
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module ebac_core
   import ebac_pkg::*;
(
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   // AXI4-Lite write
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // CPU side
   output logic o_cpu_stall,
   output logic o_irq
);

   // All block state except the array storage in one record
   typedef struct packed {
      ebac_bus_s bus;
      ebac_state_e st;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic [7:0] addr;
      logic [7:0] data;
      logic [1:0] mode;
      logic rie;
      logic arm;
      logic [2:0] arm_cnt;
      logic [2:0] stall_cnt;
      logic [1:0] div_cnt;
      logic [15:0] tick_cnt;
      logic [7:0] op_addr;
      logic [7:0] op_data;
      logic [1:0] op_mode;
      logic [EBAC_NUM_EV-1:0] stat;
      logic [EBAC_NUM_EV-1:0] ien;
      logic stall;
      logic irq;
      logic rdy_q;
   } ebac_state_s;

   ebac_state_s s_reg;
   ebac_state_s s_next;
   // Array storage; no reset, contents survive
   logic [7:0] mem_reg [EBAC_DEPTH];
   logic mem_we;
   logic [7:0] mem_wval;

   // Combined next-state logic
   always_comb begin
      logic wr_go;
      logic [7:0] wa;
      logic [7:0] wb;
      logic busy;
      logic [EBAC_NUM_EV-1:0] ev;
      logic prog_req;
      logic read_req;
      logic [1:0] rresp;
      logic [31:0] rdat;
      wr_go = 1'b0;
      wa = 8'h00;
      wb = 8'h00;
      ev = '0;
      prog_req = 1'b0;
      read_req = 1'b0;
      rresp = EBAC_RESP_OK;
      rdat = 32'h0000_0000;
      mem_we = 1'b0;
      mem_wval = 8'h00;
      s_next = s_reg;
      busy = (s_reg.st != EBAC_IDLE);
      // Capture address and data in either order
      if (s_reg.bus.awready && i_awvalid) begin
         s_next.aw_have = 1'b1;
         s_next.aw_addr = i_awaddr;
      end
      if (s_reg.bus.wready && i_wvalid) begin
         s_next.w_have = 1'b1;
         s_next.w_data = i_wdata;
         s_next.w_strb = i_wstrb;
      end
      s_next.bus.awready = !s_next.aw_have && !s_reg.bus.bvalid;
      s_next.bus.wready = !s_next.w_have && !s_reg.bus.bvalid;
      if (s_reg.bus.bvalid && i_bready) begin
         s_next.bus.bvalid = 1'b0;
      end
      // Register write once both halves are here
      if (s_reg.aw_have && s_reg.w_have && !s_reg.bus.bvalid) begin
         wr_go = 1'b1;
         wa = s_reg.aw_addr;
         wb = s_reg.w_data[7:0];
         s_next.aw_have = 1'b0;
         s_next.w_have = 1'b0;
         s_next.bus.bvalid = 1'b1;
         s_next.bus.bresp = EBAC_RESP_OK;
         s_next.bus.awready = 1'b0;
         s_next.bus.wready = 1'b0;
         if (!s_reg.w_strb[0]) begin
            wr_go = 1'b0;
         end
      end
      // Arm window count-up
      if (s_reg.arm) begin
         if (s_reg.arm_cnt == 3'(EBAC_ARM_CYC - 1)) begin
            s_next.arm = 1'b0;
            s_next.arm_cnt = 3'h0;
         end else begin
            s_next.arm_cnt = s_reg.arm_cnt + 3'h1;
         end
      end
      if (wr_go) begin
         case (wa)
            EBAC_OFF_CTRL: begin
               if (!busy) begin
                  s_next.mode = wb[EBAC_B_MODE +: 2];
               end
               s_next.rie = wb[EBAC_B_RIE];
               if (wb[EBAC_B_ARM] && !s_reg.arm) begin
                  s_next.arm = 1'b1;
                  s_next.arm_cnt = 3'h0;
               end
               prog_req = wb[EBAC_B_PROG];
               read_req = wb[EBAC_B_READ];
            end
            EBAC_OFF_ADDR: begin
               if (!busy) begin
                  s_next.addr = wb;
               end else begin
                  ev[1] = 1'b1;
               end
            end
            EBAC_OFF_DATA: begin
               s_next.data = wb;
            end
            EBAC_OFF_CLR: begin
               s_next.stat = s_reg.stat & ~wb[EBAC_NUM_EV-1:0];
            end
            EBAC_OFF_IEN: begin
               s_next.ien = wb[EBAC_NUM_EV-1:0];
            end
            default: begin
               s_next.bus.bresp = EBAC_RESP_SLVERR;
            end
         endcase
      end
      // Operation sequencer
      case (s_reg.st)
         EBAC_IDLE: begin
            if (read_req) begin
               s_next.data = mem_reg[s_reg.addr];
               s_next.stall = 1'b1;
               s_next.stall_cnt = 3'(EBAC_READ_STALL - 1);
            end else if (prog_req && s_reg.arm
                         && s_next.mode != EBAC_MODE_RSVD) begin
               s_next.st = EBAC_STALL;
               s_next.op_addr = s_reg.addr;
               s_next.op_data = s_reg.data;
               s_next.op_mode = s_next.mode;
               s_next.arm = 1'b0;
               s_next.div_cnt = 2'h0;
               s_next.tick_cnt = 16'h0000;
               s_next.stall = 1'b1;
               s_next.stall_cnt = 3'(EBAC_PROG_STALL - 1);
            end
         end
         EBAC_STALL, EBAC_BUSY: begin
            if (read_req || prog_req) begin
               ev[1] = 1'b1;
            end
            if (s_reg.st == EBAC_STALL && !s_reg.stall) begin
               s_next.st = EBAC_BUSY;
            end
            if (s_reg.div_cnt == 2'(EBAC_OSC_DIV - 1)) begin
               s_next.div_cnt = 2'h0;
               s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
            end else begin
               s_next.div_cnt = s_reg.div_cnt + 2'h1;
            end
            if (s_reg.tick_cnt == 16'((s_reg.op_mode == EBAC_MODE_ATOMIC)
                  ? EBAC_ATOMIC_TICKS : EBAC_SPLIT_TICKS)) begin
               s_next.st = EBAC_IDLE;
               mem_we = 1'b1;
               ev[0] = 1'b1;
               case (s_reg.op_mode)
                  EBAC_MODE_ATOMIC: mem_wval = s_reg.op_data;
                  EBAC_MODE_ERASE: mem_wval = EBAC_ERASED;
                  EBAC_MODE_WRITE:
                     mem_wval = mem_reg[s_reg.op_addr] & s_reg.op_data;
                  default: mem_wval = mem_reg[s_reg.op_addr];
               endcase
            end
         end
         default: begin
            s_next.st = EBAC_IDLE;
         end
      endcase
      // Stall countdown
      if (s_reg.stall && !(read_req || prog_req)) begin
         if (s_reg.stall_cnt == 3'h0) begin
            s_next.stall = 1'b0;
         end else begin
            s_next.stall_cnt = s_reg.stall_cnt - 3'h1;
         end
      end
      // Sticky events: set wins over clear
      s_next.stat = s_next.stat | ev;
      // Read channel
      if (s_reg.bus.rvalid && i_rready) begin
         s_next.bus.rvalid = 1'b0;
      end
      s_next.bus.arready = !s_next.bus.rvalid;
      if (s_reg.bus.arready && i_arvalid) begin
         case (i_araddr)
            EBAC_OFF_CTRL: begin
               rdat[EBAC_B_MODE +: 2] = s_reg.mode;
               rdat[EBAC_B_RIE] = s_reg.rie;
               rdat[EBAC_B_ARM] = s_reg.arm;
               rdat[EBAC_B_PROG] = busy;
            end
            EBAC_OFF_ADDR: rdat[7:0] = s_reg.addr;
            EBAC_OFF_DATA: rdat[7:0] = s_reg.data;
            EBAC_OFF_STAT: rdat[EBAC_NUM_EV-1:0] = s_reg.stat;
            EBAC_OFF_IEN: rdat[EBAC_NUM_EV-1:0] = s_reg.ien;
            EBAC_OFF_CLR: rdat = 32'h0000_0000;
            default: rresp = EBAC_RESP_SLVERR;
         endcase
         s_next.bus.rvalid = 1'b1;
         s_next.bus.rdata = rdat;
         s_next.bus.rresp = rresp;
         s_next.bus.arready = 1'b0;
      end
      s_next.rdy_q = (s_next.st == EBAC_IDLE) && s_next.rie;
      s_next.irq = s_next.rdy_q || |(s_next.stat & s_next.ien);
   end

   // Register the state record
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         if (s_reg.st == EBAC_IDLE) begin
            s_reg <= '0;
            s_reg.st <= EBAC_IDLE;
         end else begin
            s_reg.bus <= '0;
            s_reg.aw_have <= 1'b0;
            s_reg.w_have <= 1'b0;
            s_reg.stall <= 1'b0;
            s_reg.arm <= 1'b0;
            s_reg.rie <= 1'b0;
            s_reg.stat <= '0;
            s_reg.ien <= '0;
            s_reg.irq <= 1'b0;
            s_reg.st <= EBAC_BUSY;
            s_reg.div_cnt <= s_next.div_cnt;
            s_reg.tick_cnt <= s_next.tick_cnt;
            if (s_next.st == EBAC_IDLE) begin
               s_reg.st <= EBAC_IDLE;
            end
         end
      end else if (i_ce) begin
         s_reg <= s_next;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_ce && mem_we) begin
         mem_reg[s_reg.op_addr] <= mem_wval;
      end
   end

   // Outputs straight from flops
   assign o_awready = s_reg.bus.awready;
   assign o_wready = s_reg.bus.wready;
   assign o_bvalid = s_reg.bus.bvalid;
   assign o_bresp = s_reg.bus.bresp;
   assign o_arready = s_reg.bus.arready;
   assign o_rvalid = s_reg.bus.rvalid;
   assign o_rdata = s_reg.bus.rdata;
   assign o_rresp = s_reg.bus.rresp;
   assign o_cpu_stall = s_reg.stall;
   assign o_irq = s_reg.irq;

   // Arm raised, then four enabled cycles
   sequence ebac_seq_arm_run;
      $rose(s_reg.arm) ##0 i_ce [*4];
   endsequence
   // Program accepted, then two enabled stall cycles
   sequence ebac_seq_prog_stall;
      (s_reg.st == EBAC_IDLE) ##1 ((s_reg.st == EBAC_STALL) && i_ce) [*2];
   endsequence
   // Read strobe stall raised, then four enabled cycles
   sequence ebac_seq_read_stall;
      ($rose(o_cpu_stall) && (s_reg.st == EBAC_IDLE)) ##0 i_ce [*4];
   endsequence

   chk_arm_clears: assert property (@(posedge i_mclk) disable iff (i_reset)
      ebac_seq_arm_run |=> !s_reg.arm)
      else $error("arm bit did not self clear");
   chk_prog_stall: assert property (@(posedge i_mclk) disable iff (i_reset)
      ebac_seq_prog_stall |-> o_cpu_stall && $past(o_cpu_stall)
      ##1 !o_cpu_stall)
      else $error("program stall length wrong");
   chk_busy_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(s_reg.st == EBAC_STALL) |-> (s_reg.st != EBAC_IDLE) [*8])
      else $error("busy dropped early");
   chk_mode_lock: assert property (@(posedge i_mclk) disable iff (i_reset)
      (s_reg.st == EBAC_BUSY) && $past(s_reg.st == EBAC_BUSY)
      |-> $stable(s_reg.mode))
      else $error("mode changed while busy");
   chk_addr_lock: assert property (@(posedge i_mclk) disable iff (i_reset)
      (s_reg.st == EBAC_BUSY) && $past(s_reg.st == EBAC_BUSY)
      |-> $stable(s_reg.addr))
      else $error("address changed while busy");
   chk_ready_irq: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_irq == (((s_reg.st == EBAC_IDLE) && s_reg.rie)
                || |(s_reg.stat & s_reg.ien)))
      else $error("ready interrupt level wrong");
   chk_need_arm: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(s_reg.st == EBAC_STALL) |-> $past(s_reg.arm))
      else $error("program started unarmed");
   chk_read_stall: assert property (@(posedge i_mclk) disable iff (i_reset)
      ebac_seq_read_stall |-> o_cpu_stall && $past(o_cpu_stall)
      && $past(o_cpu_stall, 2) ##1 !o_cpu_stall)
      else $error("read stall length wrong");

endmodule // ebac_core

// ### verilog/ebac_pkg.sv
package ebac_pkg;
   // Register byte addresses (word aligned)
   localparam logic [7:0] EBAC_OFF_CTRL = 8'h00;
   localparam logic [7:0] EBAC_OFF_ADDR = 8'h04;
   localparam logic [7:0] EBAC_OFF_DATA = 8'h08;
   localparam logic [7:0] EBAC_OFF_STAT = 8'h0c;
   localparam logic [7:0] EBAC_OFF_CLR = 8'h10;
   localparam logic [7:0] EBAC_OFF_IEN = 8'h14;
   // Control field positions
   localparam int EBAC_B_READ = 0;
   localparam int EBAC_B_PROG = 1;
   localparam int EBAC_B_ARM = 2;
   localparam int EBAC_B_RIE = 3;
   localparam int EBAC_B_MODE = 4;
   // Status bits: 0 ready, 1 rejected access
   localparam int EBAC_NUM_EV = 2;
   // Programming modes
   localparam logic [1:0] EBAC_MODE_ATOMIC = 2'h0;
   localparam logic [1:0] EBAC_MODE_ERASE = 2'h1;
   localparam logic [1:0] EBAC_MODE_WRITE = 2'h2;
   localparam logic [1:0] EBAC_MODE_RSVD = 2'h3;
   localparam logic [7:0] EBAC_ERASED = 8'hff;
   localparam int EBAC_DEPTH = 256;
   // Timing
   localparam int EBAC_CLK_HZ = 20000000;
   localparam int EBAC_OSC_HZ = 8000000;
   localparam int EBAC_T_ATOMIC_US = 3400;
   localparam int EBAC_T_SPLIT_US = 1800;
   localparam int EBAC_ARM_CYC = 4;
   localparam int EBAC_READ_STALL = 4;
   localparam int EBAC_PROG_STALL = 2;
   localparam int EBAC_OSC_DIV =
      (EBAC_CLK_HZ + EBAC_OSC_HZ - 1) / EBAC_OSC_HZ;
   localparam int EBAC_ATOMIC_TICKS = EBAC_T_ATOMIC_US * 8;
   localparam int EBAC_SPLIT_TICKS = EBAC_T_SPLIT_US * 8;
   // Bus reply codes
   localparam logic [1:0] EBAC_RESP_OK = 2'h0;
   localparam logic [1:0] EBAC_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      EBAC_IDLE = 3'b001,
      EBAC_STALL = 3'b010,
      EBAC_BUSY = 3'b100
   } ebac_state_e;

   // Bus outputs
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ebac_bus_s;
endpackage

// ### dv/ebac_cpu_model.sv
`timescale 1ns/1ns
// Bus master standing in for the CPU core
module ebac_cpu_model (
   // Clock
   input wire logic i_mclk,
   // Write channels
   output logic [7:0] o_awaddr,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   output logic o_wvalid,
   input wire logic i_wready,
   input wire logic [1:0] i_bresp,
   input wire logic i_bvalid,
   output logic o_bready,
   // Read channels
   output logic [7:0] o_araddr,
   output logic o_arvalid,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   input wire logic i_rvalid,
   output logic o_rready
);
   // Idle bus at time zero
   initial begin
      o_awaddr = 8'h00;
      o_awvalid = 1'b0;
      o_wdata = 32'h0;
      o_wstrb = 4'hf;
      o_wvalid = 1'b0;
      o_bready = 1'b0;
      o_araddr = 8'h00;
      o_arvalid = 1'b0;
      o_rready = 1'b0;
   end

   // One write; the edge wait keeps back-to-back calls apart
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge i_mclk);
      o_awaddr <= a;
      o_awvalid <= 1'b1;
      o_wdata <= d;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge i_mclk);
         // Released payload shows the inverse, never the old value
         if (!aw_done && i_awready) begin
            aw_done = 1'b1;
            o_awvalid <= 1'b0;
            o_awaddr <= ~a;
         end
         if (!w_done && i_wready) begin
            w_done = 1'b1;
            o_wvalid <= 1'b0;
            o_wdata <= ~d;
         end
      end
      do @(posedge i_mclk); while (i_bvalid !== 1'b1);
      resp = i_bresp;
      o_bready <= 1'b0;
   endtask

   // One read
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] resp);
      @(posedge i_mclk);
      o_araddr <= a;
      o_arvalid <= 1'b1;
      o_rready <= 1'b1;
      do @(posedge i_mclk); while (i_arready !== 1'b1);
      o_arvalid <= 1'b0;
      o_araddr <= ~a;
      while (i_rvalid !== 1'b1) @(posedge i_mclk);
      d = i_rdata;
      resp = i_rresp;
      o_rready <= 1'b0;
   endtask
endmodule // ebac_cpu_model

// ### dv/tb.sv
`timescale 1ns/1ns
module tb;
   import ebac_pkg::*;
   logic i_mclk, i_reset, i_ce;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, o_cpu_stall, o_irq;
   int fails = 0, check_count = 0, cyc = 0, run = 0, last_run = 0;

   ebac_core u_ebac_core (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
      .o_rvalid(rvalid), .i_rready(rready), .o_cpu_stall(o_cpu_stall),
      .o_irq(o_irq));
   ebac_cpu_model u_cpu (.i_mclk(i_mclk), .o_awaddr(awaddr),
      .o_awvalid(awvalid), .i_awready(awready), .o_wdata(wdata),
      .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
      .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
      .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
      .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid),
      .o_rready(rready));

   // 20 MHz clock
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   // Stall run length and hang guard; each split op is about 43k cycles
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc >= 95000) begin
         fails++;
         stop_test();
      end
      if (o_cpu_stall === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         last_run <= run;
         run <= 0;
      end
   end

   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp,
                           input string m);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("Counts: fails=%0d checks=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Register access with an OKAY reply expected
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      u_cpu.wr(a, d, r);
      check_eq(32'(r), 32'(EBAC_RESP_OK), "bresp");
   endtask

   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      u_cpu.rd(a, d, r);
      check_eq(32'(r), 32'(EBAC_RESP_OK), "rresp");
   endtask

   // Start without arming, and arming left to lapse
   task automatic t_unarmed();
      logic [31:0] d;
      wreg(EBAC_OFF_CTRL, 32'h2);
      rreg(EBAC_OFF_CTRL, d);
      check_eq(d & 32'h2, 32'h0, "unarmed start");
      wreg(EBAC_OFF_CTRL, 32'h4);
      repeat (8) @(posedge i_mclk);
      rreg(EBAC_OFF_CTRL, d);
      check_eq(d & 32'h4, 32'h0, "arm lapse");
      wreg(EBAC_OFF_CTRL, 32'h2);
      rreg(EBAC_OFF_CTRL, d);
      check_eq(d & 32'h2, 32'h0, "late start");
   endtask

   // Erase-only with busy accesses and a reset in mid-run
   task automatic t_erase();
      logic [31:0] d;
      int t0;
      // Software order: poll, mode, addr, data, arm, start
      rreg(EBAC_OFF_CTRL, d);
      check_eq(d & 32'h2, 32'h0, "idle");
      wreg(EBAC_OFF_CTRL, 32'h10);
      wreg(EBAC_OFF_ADDR, 32'h5a);
      wreg(EBAC_OFF_DATA, 32'h0);
      wreg(EBAC_OFF_IEN, 32'h1);
      wreg(EBAC_OFF_CTRL, 32'h14);
      wreg(EBAC_OFF_CTRL, 32'h16);
      t0 = cyc;
      // Run length lands one edge after the stall drops
      repeat (3) @(posedge i_mclk);
      check_eq(32'(last_run), 32'd2, "program stall");
      rreg(EBAC_OFF_CTRL, d);
      check_eq(d & 32'h32, 32'h12, "busy set");
      check_eq(32'(o_irq), 32'h0, "irq while busy");
      wreg(EBAC_OFF_CTRL, 32'h20);
      rreg(EBAC_OFF_CTRL, d);
      check_eq(d & 32'h32, 32'h12, "mode kept");
      wreg(EBAC_OFF_ADDR, 32'h33);
      rreg(EBAC_OFF_ADDR, d);
      check_eq(d & 32'hff, 32'h5a, "addr kept");
      wreg(EBAC_OFF_CTRL, 32'h1);
      rreg(EBAC_OFF_DATA, d);
      check_eq(d & 32'hff, 32'h0, "data kept");
      rreg(EBAC_OFF_STAT, d);
      check_eq(d & 32'h2, 32'h2, "rejected flag");
      // Reset must not abort the running erase
      i_reset <= 1'b1;
      @(posedge i_mclk);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_mclk);
      rreg(EBAC_OFF_CTRL, d);
      check_eq(d & 32'h2, 32'h2, "busy after reset");
      wreg(EBAC_OFF_IEN, 32'h1);
      // Poll busy until it drops; the hang guard bounds this
      while (d[1] !== 1'b0) rreg(EBAC_OFF_CTRL, d);
      check_eq(32'(cyc - t0 >= 36000), 32'h1, "erase time");
      rreg(EBAC_OFF_STAT, d);
      check_eq(d & 32'h1, 32'h1, "done flag");
      check_eq(32'(o_irq), 32'h1, "irq raised");
      wreg(EBAC_OFF_CLR, 32'h1);
      rreg(EBAC_OFF_STAT, d);
      check_eq(d & 32'h1, 32'h0, "done cleared");
      check_eq(32'(o_irq), 32'h0, "irq cleared");
   endtask

   // Read back the erased byte
   task automatic t_read();
      logic [31:0] d;
      wreg(EBAC_OFF_ADDR, 32'h5a);
      wreg(EBAC_OFF_CTRL, 32'h1);
      repeat (5) @(posedge i_mclk);
      check_eq(32'(last_run), 32'd4, "read stall");
      rreg(EBAC_OFF_DATA, d);
      check_eq(d & 32'hff, 32'(EBAC_ERASED), "erased byte");
   endtask

   // Write-only into the byte erased above
   task automatic t_write();
      logic [31:0] d;
      rreg(EBAC_OFF_CTRL, d);
      check_eq(d & 32'h2, 32'h0, "idle again");
      wreg(EBAC_OFF_CTRL, 32'h20);
      wreg(EBAC_OFF_ADDR, 32'h5a);
      wreg(EBAC_OFF_DATA, 32'ha5);
      wreg(EBAC_OFF_CTRL, 32'h24);
      wreg(EBAC_OFF_CTRL, 32'h26);
      // Poll busy until it drops; the hang guard bounds this
      d = 32'h2;
      while (d[1] !== 1'b0) rreg(EBAC_OFF_CTRL, d);
      // Clear the data register so the read must refill it
      wreg(EBAC_OFF_DATA, 32'h0);
      wreg(EBAC_OFF_CTRL, 32'h1);
      repeat (5) @(posedge i_mclk);
      rreg(EBAC_OFF_DATA, d);
      check_eq(d & 32'hff, 32'ha5, "written byte");
   endtask

   // Unmapped address on both channels
   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0] r;
      u_cpu.wr(8'h20, 32'h1, r);
      check_eq(32'(r), 32'(EBAC_RESP_SLVERR), "write unmapped");
      u_cpu.rd(8'h20, d, r);
      check_eq(32'(r), 32'(EBAC_RESP_SLVERR), "read unmapped");
   endtask

   // Main sequence
   initial begin
      i_reset = 1'b1;
      i_ce = 1'b1;
      repeat (4) @(posedge i_mclk);
      i_reset <= 1'b0;
      @(posedge i_mclk);
      t_unmapped();
      t_unarmed();
      t_erase();
      t_read();
      t_write();
      stop_test();
   end
endmodule // tb
